// *** flash_ctrl_pkg.sv ***
// shared constants for the flash unlock, read and erase controller
package flash_ctrl_pkg;
   localparam int          ADDR_W          = 22;
   localparam int          INC_W           = 21;
   localparam logic [7:0]  KEY_WORD_1      = 8'h55;
   localparam logic [7:0]  KEY_WORD_2      = 8'hAA;
   localparam logic [7:0]  KEY_SECTOR_PROGRAM_GO_1     = 8'hDD;
   localparam logic [7:0]  KEY_SECTOR_PROGRAM_GO_2     = 8'h22;
   localparam logic [7:0]  KEY_ERASE_1     = 8'hCC;
   localparam logic [7:0]  KEY_ERASE_2     = 8'h33;
   localparam logic [7:0]  KEY_READ_1      = 8'hBB;
   localparam logic [7:0]  KEY_READ_2      = 8'h44;
   localparam int          SECTOR_LSB      = 8;
   // avalon register word addresses (byte offset / 4)
   localparam logic [3:0]  REG_KEY         = 4'h0;
   localparam logic [3:0]  REG_CMD         = 4'h1;
   localparam logic [3:0]  REG_CTRL        = 4'h2;
   localparam logic [3:0]  REG_TADDR       = 4'h3;
   localparam logic [3:0]  REG_PTR         = 4'h4;
   localparam logic [3:0]  REG_FETCH       = 4'h5;
   localparam logic [3:0]  REG_LATCH       = 4'h6;
   // op_command_reg bits
   localparam int          CMD_WORD        = 0;
   localparam int          CMD_SECTOR_PROGRAM_GO       = 1;
   localparam int          CMD_ERASE       = 2;
   localparam int          CMD_SECTOR_FETCH_GO       = 3;
   // op_control_reg bits
   localparam int          CTL_EN          = 0;
   localparam int          CTL_FAULT       = 1;
   localparam int          CTL_DONE        = 2;
   localparam int          CTL_IRQ_EN      = 3;
   localparam int          CTL_BUSY        = 4;
   // fetch modes
   localparam logic [1:0]  FETCH_PLAIN     = 2'h0;
   localparam logic [1:0]  FETCH_POST_INC  = 2'h1;
   localparam logic [1:0]  FETCH_POST_DEC  = 2'h2;
   localparam logic [1:0]  FETCH_PRE_INC   = 2'h3;
   // timing
   localparam int          CLK_HZ          = 25_000_000;
   localparam int          ERASE_TIME_US   = 10_000;
   localparam int          ERASE_CYCLES    = ERASE_TIME_US * (CLK_HZ / 1_000_000);
   localparam int          FLASH_WORDS     = 32768;
endpackage

// *** flash_link_if.sv ***
// interface between the processor-side host and the flash controller
`timescale 1ns/1ps
interface flash_link_if;
   logic        reg_wr;
   logic [3:0]  reg_addr;
   logic [23:0] reg_wdata;
   logic        fetch_req;
   logic [1:0]  fetch_mode;
   logic [7:0]  latch_data;
   logic [7:0]  ctrl_rd;
   logic [21:0] ptr_rd;
   logic        cpu_stall;
   logic        done_irq;
   logic        flash_rd_en;
   logic [20:0] flash_addr;
   logic [15:0] flash_rdata;
   logic        erase_go;
   logic [13:0] erase_sector;
   logic        erase_abort;
   logic        disturb;
   modport device (input reg_wr, reg_addr, reg_wdata, fetch_req, fetch_mode, disturb,
                   flash_rdata, erase_abort,
                   output latch_data, ctrl_rd, ptr_rd, cpu_stall, done_irq,
                   flash_rd_en, flash_addr, erase_go, erase_sector);
   modport host (output reg_wr, reg_addr, reg_wdata, fetch_req, fetch_mode, disturb,
                 input latch_data, ctrl_rd, ptr_rd, cpu_stall, done_irq);
endinterface

// *** flash_ctrl_device.sv ***
// flash controller: byte fetch, unlock checking, sector erase
// Notes on behaviour
// - byte fetch loads one flash byte into latch
// - stall cpu during fetch, latch valid next
// - pointer bit zero picks high or low byte
// - key pairs arm word, sector write, read
// - CCh then 33h arms erase
// - software writes keys then operation bit
// - disturbed or late sequence cancels operation
// - program flash operations stall the cpu
// - software disables interrupts around unlock
// - protected operations need successful unlock
// - erase unit is one whole sector
// - address bits 21:8 pick sector, rest ignored
// - enable bit required, erase bit starts erase
// - software loads address, enables, unlocks, erases
// - protected address clears erase, sets fault
// - completion clears erase bit, sets done, irq
// - erase keeps enable bit unchanged
// - internal timer ends erase, cpu halted
// - cut-short erase sets fault flag
// - invalid address erase sets fault flag
// - fetch may auto step pointer before/after
// - pointer 22 bits, top bit config space
// - stepping changes only low 21 bits
//
// The Avalon-MM register port and the register addresses were decided locally.
`timescale 1ns/1ps
module flash_ctrl_device
   import flash_ctrl_pkg::*;
#(
   parameter int ERASE_CNT = ERASE_CYCLES,
   parameter int WP_SECTOR_LIMIT = 0
) (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic nrst,
   // link
   flash_link_if.device lnk,
   // write protection from configuration
   input  wire logic [13:0] wp_below_sector
);
   import flash_ctrl_pkg::*;

   initial begin
      if (ERASE_CNT < 1) $error("ERASE_CNT must be positive");
   end

   typedef enum logic [1:0] {K_IDLE, K_FIRST, K_ARMED} key_e;
   typedef enum logic [1:0] {OP_IDLE, OP_FETCH, OP_ERASE} op_e;

   key_e        key_reg;
   op_e         op_reg;
   logic [7:0]  first_reg;
   logic [3:0]  armed_reg;
   logic [3:0]  cmd_reg;
   logic        en_reg;
   logic        fault_reg;
   logic        done_reg;
   logic        irq_en_reg;
   logic [21:0] taddr_reg;
   logic [21:0] ptr_reg;
   logic [7:0]  latch_reg;
   logic [1:0]  mode_reg;
   logic [31:0] cnt_reg;

   wire key_wr  = lnk.reg_wr && lnk.reg_addr == REG_KEY;
   wire cmd_wr  = lnk.reg_wr && lnk.reg_addr == REG_CMD;
   wire ctl_wr  = lnk.reg_wr && lnk.reg_addr == REG_CTRL;
   wire [7:0] kv = lnk.reg_wdata[7:0];
   // second key decode selects which operation is armed
   wire [3:0] pair_ok = {first_reg == KEY_READ_1  && kv == KEY_READ_2,
                         first_reg == KEY_ERASE_1 && kv == KEY_ERASE_2,
                         first_reg == KEY_SECTOR_PROGRAM_GO_1 && kv == KEY_SECTOR_PROGRAM_GO_2,
                         first_reg == KEY_WORD_1  && kv == KEY_WORD_2};
   wire first_ok = kv == KEY_WORD_1 || kv == KEY_SECTOR_PROGRAM_GO_1 ||
                   kv == KEY_ERASE_1 || kv == KEY_READ_1;
   wire [13:0] sector  = taddr_reg[21:SECTOR_LSB];
   wire addr_bad = taddr_reg[21] || (taddr_reg[20:0] >= 21'(2 * FLASH_WORDS));
   wire wp_hit   = sector < wp_below_sector;
   wire erase_req = cmd_wr && lnk.reg_wdata[CMD_ERASE] && key_reg == K_ARMED
                    && armed_reg[CMD_ERASE] && en_reg && !lnk.disturb;
   wire erase_ok  = erase_req && !wp_hit && !addr_bad;
   wire erase_end = op_reg == OP_ERASE && cnt_reg == 32'(ERASE_CNT - 1);
   wire erase_cut = op_reg == OP_ERASE && lnk.erase_abort;
   wire [21:0] ptr_step = lnk.fetch_mode == FETCH_POST_DEC ?
                          {ptr_reg[21], ptr_reg[20:0] - 21'h1} :
                          {ptr_reg[21], ptr_reg[20:0] + 21'h1};
   wire [21:0] fetch_addr = lnk.fetch_mode == FETCH_PRE_INC ? ptr_step : ptr_reg;
   wire fetch_start = lnk.fetch_req && op_reg == OP_IDLE;

   assign lnk.latch_data   = latch_reg;
   assign lnk.ptr_rd       = ptr_reg;
   assign lnk.ctrl_rd      = {3'h0, op_reg != OP_IDLE, irq_en_reg, done_reg, fault_reg, en_reg};
   assign lnk.cpu_stall    = op_reg != OP_IDLE || fetch_start;
   assign lnk.done_irq     = done_reg && irq_en_reg;
   assign lnk.flash_rd_en  = op_reg == OP_FETCH;
   assign lnk.flash_addr   = ptr_reg[20:0];
   assign lnk.erase_go     = op_reg == OP_ERASE;
   assign lnk.erase_sector = sector;

   // unlock sequencer: must advance on consecutive cycles
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         key_reg   <= K_IDLE;
         first_reg <= 8'h00;
         armed_reg <= 4'h0;
      end else if (lnk.disturb) begin
         key_reg   <= K_IDLE;
         armed_reg <= 4'h0;
      end else begin
         unique case (key_reg)
            K_IDLE: if (key_wr && first_ok) begin
               key_reg   <= K_FIRST;
               first_reg <= kv;
            end
            K_FIRST: if (key_wr && |pair_ok) begin
               key_reg   <= K_ARMED;
               armed_reg <= pair_ok;
            end else begin
               key_reg <= K_IDLE;
            end
            K_ARMED: begin
               key_reg   <= K_IDLE;
               armed_reg <= 4'h0;
            end
         endcase
      end
   end

   // operation sequencer
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         op_reg    <= OP_IDLE;
         cnt_reg   <= 32'h0;
         latch_reg <= 8'h00;
         mode_reg  <= FETCH_PLAIN;
      end else begin
         unique case (op_reg)
            OP_IDLE: if (erase_ok) begin
               op_reg  <= OP_ERASE;
               cnt_reg <= 32'h0;
            end else if (fetch_start) begin
               op_reg   <= OP_FETCH;
               mode_reg <= lnk.fetch_mode;
            end
            OP_FETCH: begin
               latch_reg <= ptr_reg[0] ? lnk.flash_rdata[15:8]
                                       : lnk.flash_rdata[7:0];
               op_reg    <= OP_IDLE;
            end
            OP_ERASE: begin
               cnt_reg <= cnt_reg + 32'h1;
               if (erase_end || erase_cut) op_reg <= OP_IDLE;
            end
            default: op_reg <= OP_IDLE;
         endcase
      end
   end

   // registers written by software, pointer and flags
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cmd_reg    <= 4'h0;
         en_reg     <= 1'b0;
         fault_reg  <= 1'b0;
         done_reg   <= 1'b0;
         irq_en_reg <= 1'b0;
         taddr_reg  <= 22'h0;
         ptr_reg    <= 22'h0;
      end else begin
         if (lnk.reg_wr && lnk.reg_addr == REG_TADDR && op_reg == OP_IDLE)
            taddr_reg <= lnk.reg_wdata[21:0];
         if (lnk.reg_wr && lnk.reg_addr == REG_PTR && op_reg == OP_IDLE)
            ptr_reg <= lnk.reg_wdata[21:0];
         else if (fetch_start)
            ptr_reg <= fetch_addr;
         else if (op_reg == OP_FETCH && mode_reg != FETCH_PLAIN && mode_reg != FETCH_PRE_INC)
            ptr_reg <= mode_reg == FETCH_POST_DEC ? {ptr_reg[21], ptr_reg[20:0] - 21'h1}
                                                  : {ptr_reg[21], ptr_reg[20:0] + 21'h1};
         if (ctl_wr) begin
            en_reg     <= lnk.reg_wdata[CTL_EN];
            irq_en_reg <= lnk.reg_wdata[CTL_IRQ_EN];
         end
         cmd_reg[CMD_ERASE] <= erase_ok ? 1'b1 :
                               (erase_end || erase_cut) ? 1'b0 : cmd_reg[CMD_ERASE];
         cmd_reg[CMD_WORD]  <= 1'b0;
         cmd_reg[CMD_SECTOR_PROGRAM_GO] <= 1'b0;
         cmd_reg[CMD_SECTOR_FETCH_GO] <= 1'b0;
         // fault and done: set wins over a software clear
         if ((erase_req && (wp_hit || addr_bad)) || erase_cut)
            fault_reg <= 1'b1;
         else if (ctl_wr && !lnk.reg_wdata[CTL_FAULT])
            fault_reg <= 1'b0;
         if (erase_end && !erase_cut)
            done_reg <= 1'b1;
         else if (ctl_wr && !lnk.reg_wdata[CTL_DONE])
            done_reg <= 1'b0;
      end
   end
endmodule

// *** flash_ctrl_host.sv ***
// host end: avalon-mm slave that drives the controller link
`timescale 1ns/1ps
module flash_ctrl_host
   import flash_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   // avalon-mm slave
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // link
   flash_link_if.host       lnk
);
   import flash_ctrl_pkg::*;

   logic [31:0] rdata_reg;
   logic        rvalid_reg;
   logic        wdone_reg;

   wire [3:0] word  = avs_address[5:2];
   wire is_fetch    = word == REG_FETCH;
   // writes are held off while the controller stalls the cpu
   // busy comes from a register, so the fetch request cannot loop back into its own gate
   wire busy        = lnk.ctrl_rd[CTL_BUSY];
   wire wr_go       = avs_write && !wdone_reg && !busy;
   wire [31:0] rmux = word == REG_CTRL  ? {24'h0, lnk.ctrl_rd} :
                      word == REG_PTR   ? {10'h0, lnk.ptr_rd} :
                      word == REG_LATCH ? {24'h0, lnk.latch_data} : 32'h0;

   assign lnk.reg_wr     = wr_go && !is_fetch;
   assign lnk.reg_addr   = word;
   assign lnk.reg_wdata  = avs_writedata[23:0];
   assign lnk.fetch_req  = wr_go && is_fetch;
   assign lnk.fetch_mode = avs_writedata[1:0];
   assign lnk.disturb    = 1'b0;
   assign avs_readdata   = rdata_reg;
   assign avs_waitrequest = (avs_read && !rvalid_reg) || (avs_write && !wdone_reg);

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rdata_reg  <= 32'h0;
         rvalid_reg <= 1'b0;
         wdone_reg  <= 1'b0;
      end else begin
         rvalid_reg <= avs_read && !rvalid_reg && !busy;
         if (avs_read && !rvalid_reg) rdata_reg <= rmux;
         wdone_reg  <= wr_go;
      end
   end
endmodule

// *** flash_ctrl_props.sv ***
// concurrent checks on the joined host-to-controller link
`timescale 1ns/1ps
module flash_ctrl_props
   import flash_ctrl_pkg::*;
(
   // clock and reset
   input logic        sys_clk,
   input logic        nrst,
   // link signals
   input logic        reg_wr,
   input logic [23:0] reg_wdata,
   input logic        fetch_req,
   input logic [1:0]  fetch_mode,
   input logic [7:0]  latch_data,
   input logic [7:0]  ctrl_rd,
   input logic [21:0] ptr_rd,
   input logic        cpu_stall,
   input logic        done_irq,
   input logic        flash_rd_en,
   input logic [20:0] flash_addr,
   input logic [15:0] flash_rdata,
   input logic        erase_go,
   input logic [13:0] erase_sector
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   a_fetch_stalls: assert property (fetch_req |=> flash_rd_en && cpu_stall)
      else $error("fetch did not read flash with cpu stalled");
   a_fetch_addr: assert property (fetch_req && fetch_mode != FETCH_PRE_INC
      |=> flash_addr == $past(ptr_rd[20:0]))
      else $error("fetch address differs from pointer");
   a_latch_byte: assert property (flash_rd_en |=> latch_data == ($past(flash_addr[0])
      ? $past(flash_rdata[15:8]) : $past(flash_rdata[7:0])))
      else $error("latch holds wrong byte of word");
   a_plain_keeps: assert property (fetch_req && fetch_mode == FETCH_PLAIN
      |-> ##2 ptr_rd == $past(ptr_rd, 2))
      else $error("plain fetch moved pointer");
   a_post_inc: assert property (fetch_req && fetch_mode == FETCH_POST_INC
      |-> ##2 ptr_rd[20:0] == $past(ptr_rd[20:0], 2) + 21'h1)
      else $error("post increment step wrong");
   a_top_bit: assert property (fetch_req |-> ##2 ptr_rd[21] == $past(ptr_rd[21], 2))
      else $error("pointer top bit changed by step");
   a_erase_stall: assert property (erase_go |-> cpu_stall)
      else $error("erase running without cpu stall");
   a_erase_keys: assert property ($rose(erase_go) |-> $past(reg_wdata[7:0], 2) == KEY_ERASE_2
      && $past(reg_wdata[7:0], 3) == KEY_ERASE_1 && ctrl_rd[CTL_EN])
      else $error("erase started without unlock");
   a_sector_hold: assert property (erase_go && $past(erase_go) |-> $stable(erase_sector))
      else $error("erase sector moved mid erase");
   a_erase_end: assert property ($fell(erase_go) |-> ##[0:2] ctrl_rd[CTL_DONE] && ctrl_rd[CTL_EN])
      else $error("erase end without done flag");
   a_irq_cause: assert property (done_irq |-> ctrl_rd[CTL_DONE] && ctrl_rd[CTL_IRQ_EN])
      else $error("irq without done and enable");
endmodule

// *** tb.sv ***
// testbench: avalon fetches on the joined link, direct unlock and erase on a second link
`timescale 1ns/1ps
module tb;
   import flash_ctrl_pkg::*;
   localparam int EC = 8;
   logic        sys_clk = 1'b0;
   logic        nrst = 1'b0;
   logic [5:0]  avs_address = '0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = '0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [13:0] wp = 14'h0004;
   logic [31:0] exp_q[$];
   int          mismatches = 0;
   int          checked = 0;
   flash_link_if lnk();
   flash_link_if lnk2();
   always #20 sys_clk = ~sys_clk;
   function automatic logic [15:0] fword(input logic [20:0] a);
      return {a[8:1] ^ a[16:9] ^ 8'hA5, a[8:1] ^ a[16:9]};
   endfunction
   // released array shows the inverse word
   assign lnk.flash_rdata = lnk.flash_rd_en ? fword(lnk.flash_addr) : ~fword(lnk.flash_addr);
   assign lnk2.flash_rdata = ~fword(lnk2.flash_addr);
   assign lnk.erase_abort = 1'b0;
   flash_ctrl_host i_flash_ctrl_host (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .lnk(lnk.host));
   flash_ctrl_device #(.ERASE_CNT(EC)) i_flash_ctrl_device (.sys_clk(sys_clk), .nrst(nrst),
      .lnk(lnk.device), .wp_below_sector(wp));
   flash_ctrl_device #(.ERASE_CNT(EC)) i_flash_ctrl_device_b (.sys_clk(sys_clk), .nrst(nrst),
      .lnk(lnk2.device), .wp_below_sector(wp));
   flash_ctrl_props i_flash_ctrl_props (.sys_clk(sys_clk), .nrst(nrst), .reg_wr(lnk.reg_wr),
      .reg_wdata(lnk.reg_wdata), .fetch_req(lnk.fetch_req), .fetch_mode(lnk.fetch_mode),
      .latch_data(lnk.latch_data), .ctrl_rd(lnk.ctrl_rd), .ptr_rd(lnk.ptr_rd),
      .cpu_stall(lnk.cpu_stall), .done_irq(lnk.done_irq), .flash_rd_en(lnk.flash_rd_en),
      .flash_addr(lnk.flash_addr), .flash_rdata(lnk.flash_rdata), .erase_go(lnk.erase_go),
      .erase_sector(lnk.erase_sector));
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic av_go(input logic [3:0] a, input logic [31:0] d, input logic rd);
      avs_address <= {a, 2'b00};
      avs_writedata <= d;
      avs_read <= rd;
      avs_write <= !rd;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic av_rd(input logic [3:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      av_go(a, 32'h0, 1'b1);
   endtask
   always @(posedge sys_clk) begin
      if (avs_read && avs_waitrequest === 1'b0) cmp("readdata", exp_q.pop_front(), avs_readdata);
   end
   task automatic fetch_case(input logic [1:0] m, input logic [21:0] p, input bit chk);
      logic [20:0] fa;
      logic [21:0] q;
      logic [15:0] w;
      fa = (m == FETCH_PRE_INC) ? p[20:0] + 21'h1 : p[20:0];
      q = {p[21], (m == FETCH_PLAIN) ? p[20:0] : (m == FETCH_POST_DEC) ? p[20:0] - 21'h1
         : p[20:0] + 21'h1};
      w = fword(fa);
      av_go(REG_PTR, {10'h0, p}, 1'b0);
      av_go(REG_FETCH, {30'h0, m}, 1'b0);
      if (chk) av_rd(REG_LATCH, {24'h0, fa[0] ? w[15:8] : w[7:0]});
      av_rd(REG_PTR, {10'h0, q});
   endtask
   task automatic l_wr(input logic [3:0] a, input logic [23:0] d);
      lnk2.reg_wr <= 1'b1;
      lnk2.reg_addr <= a;
      lnk2.reg_wdata <= d;
      @(posedge sys_clk);
   endtask
   task automatic l_idle(input int n);
      lnk2.reg_wr <= 1'b0;
      lnk2.disturb <= 1'b0;
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic erase_case(input logic [7:0] en, k2, input bit gap, dis, ab,
         input logic [21:0] ta, input logic gx, fx);
      int n;
      logic [13:0] sec;
      logic stall_ok;
      n = 0;
      stall_ok = 1'b1;
      l_wr(REG_TADDR, {2'h0, ta});
      l_wr(REG_CTRL, {16'h0, en});
      l_idle(1);
      l_wr(REG_KEY, {16'h0, KEY_ERASE_1});
      if (gap) l_idle(1);
      lnk2.disturb <= dis;
      l_wr(REG_KEY, {16'h0, k2});
      l_wr(REG_CMD, 24'h1 << CMD_ERASE);
      l_idle(0);
      repeat (EC + 6) begin
         @(posedge sys_clk);
         lnk2.erase_abort <= ab && n == 2;
         if (lnk2.erase_go === 1'b1) begin
            if (n == 0) sec = lnk2.erase_sector;
            if (lnk2.cpu_stall !== 1'b1) stall_ok = 1'b0;
            n++;
         end
      end
      cmp("erase_go", gx, n > 0);
      if (fx !== 1'bx) cmp("fault", fx, lnk2.ctrl_rd[CTL_FAULT]);
      if (gx) cmp("erase_sector", ta[21:8], sec);
      if (gx) cmp("stall", 1'b1, stall_ok);
      if (gx && !ab) cmp("erase_len", 1'b1, n >= EC - 3 && n <= EC + 1);
      if (gx && !ab) cmp("ctrl", 8'h0D, lnk2.ctrl_rd);
      if (gx && !ab) cmp("done_irq", 1'b1, lnk2.done_irq);
      l_wr(REG_CTRL, 24'h1);
      l_idle(2);
   endtask
   task automatic tally_and_finish;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      lnk2.reg_wr = 1'b0;
      lnk2.reg_addr = '0;
      lnk2.reg_wdata = '0;
      lnk2.fetch_req = 1'b0;
      lnk2.fetch_mode = '0;
      lnk2.disturb = 1'b0;
      lnk2.erase_abort = 1'b0;
      void'($urandom(32'hB684D385));
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      av_rd(REG_CTRL, 32'h0);
      av_rd(REG_PTR, 32'h0);
      av_go(4'hF, 32'hFFFF_FFFF, 1'b0);
      av_rd(4'hF, 32'h0);
      $display("test reset and map done");
      for (int i = 0; i < 4; i++) fetch_case(i[1:0], {1'b0, 21'($urandom)}, 1'b1);
      fetch_case(FETCH_POST_INC, 22'h3FFFFF, 1'b0);
      fetch_case(FETCH_POST_DEC, 22'h200000, 1'b0);
      $display("test byte fetch done");
      erase_case(8'h09, KEY_ERASE_2, 0, 0, 0, {6'h0, 8'h05, 8'($urandom)}, 1'b1, 1'b0);
      erase_case(8'h01, KEY_ERASE_2, 0, 0, 0, 22'h000277, 1'b0, 1'b1);
      erase_case(8'h01, KEY_ERASE_2, 0, 0, 0, 22'h200500, 1'b0, 1'b1);
      erase_case(8'h01, 8'h34, 0, 0, 0, 22'h000600, 1'b0, 1'bx);
      erase_case(8'h01, KEY_ERASE_2, 1, 0, 0, 22'h000600, 1'b0, 1'bx);
      erase_case(8'h01, KEY_ERASE_2, 0, 1, 0, 22'h000600, 1'b0, 1'bx);
      erase_case(8'h00, KEY_ERASE_2, 0, 0, 0, 22'h000600, 1'b0, 1'bx);
      erase_case(8'h01, KEY_ERASE_2, 0, 0, 1, 22'h0006FF, 1'b1, 1'b1);
      $display("test unlock and erase done");
      tally_and_finish;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      tally_and_finish;
   end
endmodule
